// File: rtl/pel_regs.svh
// register offsets, field positions, reset values and limits of the event log
`ifndef PEL_REGS_SVH
`define PEL_REGS_SVH
`define PEL_CTRL 8'h00
`define PEL_CAP 8'h04
`define PEL_MASK 8'h08
`define PEL_COUNT 8'h0c
`define PEL_POP 8'h10
`define PEL_REREAD 8'h14
`define PEL_DATE 8'h18
`define PEL_TIME 8'h1c
`define PEL_FAULT 8'h20
`define PEL_PANEL_CTRL 8'h24
`define PEL_PANEL_CODE 8'h28
`define PEL_PANEL_DATE 8'h2c
`define PEL_PANEL_TIME 8'h30
`define PEL_IRQ_STAT 8'h34
`define PEL_IRQ_MASK 8'h38
`define PEL_CTRL_ORDER 0
`define PEL_CTRL_SCALE 1
`define PEL_CTRL_POPUP 2
`define PEL_CTRL_CLR 3
`define PEL_PAN_FWD 0
`define PEL_PAN_BACK 1
`define PEL_PAN_ACK 2
`define PEL_IRQ_NEW 0
`define PEL_IRQ_OVF 1
`define PEL_CAP_RST 200
`define PEL_CAP_MIN 50
`define PEL_CTRL_RST 3'h4
`define PEL_RESP_OKAY 2'h0
`define PEL_RESP_SLVERR 2'h2
`endif

// File: rtl/pel_pkg.sv
// types shared by the event log
package pel_pkg;
  typedef enum logic [1:0] {
    PEL_START_ON = 2'b00,
    PEL_START_OFF = 2'b01,
    PEL_TRIP_ON = 2'b10,
    PEL_TRIP_OFF = 2'b11
  } pel_evt_t;
  typedef struct packed {
    logic [31:0] date;
    logic [31:0] tod;
  } pel_stamp_t;
  typedef struct packed {
    logic ovf;
    logic [7:0] chan;
    logic [7:0] num;
    pel_stamp_t stamp;
    logic [15:0] fault;
  } pel_entry_t;
endpackage

// File: rtl/pel_event_log.sv
// circular protection event log with axi4-lite register access
`include "pel_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module pel_event_log import pel_pkg::*; #(
  parameter int NSTG = 8,
  parameter int MAX_DEPTH = 2000,
  parameter logic [7:0] CH_BASE = 8'h00
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // protection stages and system time
  input wire logic [NSTG-1:0] stage_start,
  input wire logic [NSTG-1:0] stage_trip,
  input wire pel_stamp_t stamp,
  input wire logic [15:0] fault_pu,
  input wire logic [15:0] fault_pri,
  // indications
  output logic popup,
  output logic irq
);
  localparam int NEV = 4 * NSTG;
  localparam int CW = $clog2(MAX_DEPTH + 1);
  localparam int EW = $clog2(NEV);
  localparam logic [CW-1:0] CAP_MIN = CW'(`PEL_CAP_MIN);
  localparam logic [CW-1:0] CAP_MAX = CW'(MAX_DEPTH);

  function automatic logic [CW-1:0] phys(input logic [CW-1:0] t, input logic [CW-1:0] off,
                                         input logic [CW-1:0] c);
    logic [CW:0] s;
    s = {1'b0, t} + {1'b0, off};
    return (s >= {1'b0, c}) ? CW'(s - {1'b0, c}) : CW'(s);
  endfunction

  function automatic logic [EW-1:0] first(input logic [NEV-1:0] v);
    first = '0;
    for (int i = NEV - 1; i >= 0; i--) begin
      if (v[i]) begin
        first = EW'(i);
      end
    end
  endfunction

  function automatic logic [31:0] code(input pel_entry_t e, input logic v);
    return {v, e.ovf, 14'h0, e.chan, e.num};
  endfunction

  pel_entry_t mem [MAX_DEPTH];
  logic awready_ff, bvalid_ff, arready_ff, rvalid_ff, popup_ff, irq_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic [NSTG-1:0] start_q_ff, trip_q_ff;
  logic [NEV-1:0] pend_ff, mask_ff, trans;
  logic [2:0] cfg_ff;
  logic [CW-1:0] cap_ff, cnt_ff, tail_ff, rd_off_ff, pan_off_ff;
  logic [1:0] istat_ff, imask_ff;
  pel_entry_t shadow_ff;
  logic shadow_v_ff;

  // edge detect on each stage start and trip level
  for (genvar g = 0; g < NSTG; g++) begin : g_tr
    assign trans[4*g+PEL_START_ON] = stage_start[g] & ~start_q_ff[g];
    assign trans[4*g+PEL_START_OFF] = ~stage_start[g] & start_q_ff[g];
    assign trans[4*g+PEL_TRIP_ON] = stage_trip[g] & ~trip_q_ff[g];
    assign trans[4*g+PEL_TRIP_OFF] = ~stage_trip[g] & trip_q_ff[g];
  end

  // bus decode
  wire aw_take = awvalid & awready_ff;
  wire ar_take = arvalid & arready_ff;
  wire [31:0] wmask = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
  wire [31:0] wd = wdata & wmask;
  wire w_ctrl = aw_take && awaddr == `PEL_CTRL;
  wire w_cap = aw_take && awaddr == `PEL_CAP;
  wire w_mask = aw_take && awaddr == `PEL_MASK;
  wire w_pan = aw_take && awaddr == `PEL_PANEL_CTRL;
  wire w_istat = aw_take && awaddr == `PEL_IRQ_STAT;
  wire w_imask = aw_take && awaddr == `PEL_IRQ_MASK;
  wire w_hit = w_ctrl | w_cap | w_mask | w_pan | w_istat | w_imask;
  wire [31:0] cap_mrg = ({{(32 - CW){1'b0}}, cap_ff} & ~wmask) | wd;
  wire [CW-1:0] cap_new = (cap_mrg < 32'(`PEL_CAP_MIN)) ? CAP_MIN :
                          (cap_mrg > 32'(MAX_DEPTH)) ? CAP_MAX : CW'(cap_mrg);
  wire [2:0] cfg_new = (cfg_ff & ~wmask[2:0]) | wd[2:0];
  wire clr_go = (w_ctrl && wd[`PEL_CTRL_CLR]) || w_cap;

  // event selection and entry build
  wire [NEV-1:0] ready_ev = pend_ff & ~mask_ff;
  wire [EW-1:0] sel = first(ready_ev);
  wire ev_go = |ready_ev && !clr_go;
  wire full = cnt_ff == cap_ff;
  wire drop = ev_go && full;
  pel_entry_t new_e;
  assign new_e.ovf = full;
  assign new_e.chan = CH_BASE + 8'(sel >> 2);
  assign new_e.num = {6'h0, sel[1:0]};
  assign new_e.stamp = stamp;
  assign new_e.fault = cfg_ff[`PEL_CTRL_SCALE] ? fault_pri : fault_pu;
  // when full, the slot of the oldest entry is reused
  wire [CW-1:0] wr_idx = full ? tail_ff : phys(tail_ff, cnt_ff, cap_ff);
  wire [CW-1:0] tail_inc = (tail_ff + 1'b1 == cap_ff) ? '0 : CW'(tail_ff + 1'b1);

  // remote reader
  wire pop_go = ar_take && araddr == `PEL_POP;
  // an empty log answers a pop with an all-zero word
  wire pop_ok = pop_go && rd_off_ff < cnt_ff;
  pel_entry_t pop_e, pan_e;
  assign pop_e = mem[phys(tail_ff, rd_off_ff, cap_ff)];
  assign pan_e = mem[phys(tail_ff, pan_off_ff, cap_ff)];
  // a drop shifts the offsets down so they stay on the same entries
  wire [CW:0] rd_t = {1'b0, rd_off_ff} + {{CW{1'b0}}, pop_ok};
  wire [CW-1:0] nxt_rd_off = (drop && rd_t != '0) ? CW'(rd_t - 1'b1) : CW'(rd_t);

  // panel cursor, direction follows display order
  wire ord = cfg_ff[`PEL_CTRL_ORDER];
  wire step_f = w_pan && wd[`PEL_PAN_FWD];
  wire step_b = w_pan && wd[`PEL_PAN_BACK];
  wire pan_up = ((step_f && !ord) || (step_b && ord)) && pan_off_ff + 1'b1 < cnt_ff;
  wire pan_dn = ((step_b && !ord) || (step_f && ord)) && pan_off_ff != '0;
  wire [CW-1:0] pan_t = pan_up ? CW'(pan_off_ff + 1'b1) : pan_dn ? CW'(pan_off_ff - 1'b1) : pan_off_ff;
  wire [CW-1:0] nxt_pan_off = (drop && pan_t != '0) ? CW'(pan_t - 1'b1) : pan_t;

  wire [CW-1:0] nxt_cnt = (ev_go && !full) ? CW'(cnt_ff + 1'b1) : cnt_ff;
  wire [CW-1:0] unread = CW'(cnt_ff - rd_off_ff);
  // a status set in the same cycle as its clear wins
  wire [1:0] nxt_istat = (istat_ff & ~(w_istat ? wd[1:0] : 2'h0)) | {drop, ev_go};
  // a new event wins over a panel acknowledge
  wire nxt_popup = cfg_ff[`PEL_CTRL_POPUP] && ((popup_ff && !(w_pan && wd[`PEL_PAN_ACK])) || ev_go);

  // read data selection
  wire r_hit = araddr inside {`PEL_CTRL, `PEL_CAP, `PEL_MASK, `PEL_COUNT, `PEL_POP, `PEL_REREAD,
                              `PEL_DATE, `PEL_TIME, `PEL_FAULT, `PEL_PANEL_CTRL, `PEL_PANEL_CODE,
                              `PEL_PANEL_DATE, `PEL_PANEL_TIME, `PEL_IRQ_STAT, `PEL_IRQ_MASK};
  wire [31:0] nxt_rdata =
    araddr == `PEL_CTRL ? {29'h0, cfg_ff} :
    araddr == `PEL_CAP ? 32'(cap_ff) :
    araddr == `PEL_MASK ? 32'(mask_ff) :
    araddr == `PEL_COUNT ? {16'(unread), 16'(cnt_ff)} :
    araddr == `PEL_POP ? (pop_ok ? code(pop_e, 1'b1) : 32'h0) :
    araddr == `PEL_REREAD ? code(shadow_ff, shadow_v_ff) :
    araddr == `PEL_DATE ? shadow_ff.stamp.date :
    araddr == `PEL_TIME ? shadow_ff.stamp.tod :
    araddr == `PEL_FAULT ? {16'h0, shadow_ff.fault} :
    araddr == `PEL_PANEL_CTRL ? 32'(pan_off_ff) :
    araddr == `PEL_PANEL_CODE ? code(pan_e, cnt_ff != '0) :
    araddr == `PEL_PANEL_DATE ? pan_e.stamp.date :
    araddr == `PEL_PANEL_TIME ? pan_e.stamp.tod :
    araddr == `PEL_IRQ_STAT ? {30'h0, istat_ff} :
    araddr == `PEL_IRQ_MASK ? {30'h0, imask_ff} : 32'h0;

  // storage array, no reset
  always_ff @(posedge aclk) begin
    if (ev_go) begin
      mem[wr_idx] <= new_e;
    end
  end

  // bus handshakes: write waits for address and data together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `PEL_RESP_OKAY;
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rresp_ff <= `PEL_RESP_OKAY;
      rdata_ff <= 32'h0;
    end else begin
      awready_ff <= awvalid && wvalid && !awready_ff && !bvalid_ff;
      bvalid_ff <= aw_take || (bvalid_ff && !bready);
      bresp_ff <= aw_take ? (w_hit ? `PEL_RESP_OKAY : `PEL_RESP_SLVERR) : bresp_ff;
      arready_ff <= arvalid && !arready_ff && !rvalid_ff;
      rvalid_ff <= ar_take || (rvalid_ff && !rready);
      rresp_ff <= ar_take ? (r_hit ? `PEL_RESP_OKAY : `PEL_RESP_SLVERR) : rresp_ff;
      rdata_ff <= ar_take ? nxt_rdata : rdata_ff;
    end
  end

  // settings and interrupt
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_ff <= `PEL_CTRL_RST;
      cap_ff <= CW'(`PEL_CAP_RST);
      mask_ff <= '0;
      imask_ff <= 2'h0;
      istat_ff <= 2'h0;
      irq_ff <= 1'b0;
      popup_ff <= 1'b0;
    end else begin
      cfg_ff <= w_ctrl ? cfg_new : cfg_ff;
      cap_ff <= w_cap ? cap_new : cap_ff;
      mask_ff <= w_mask ? NEV'((32'(mask_ff) & ~wmask) | wd) : mask_ff;
      imask_ff <= w_imask ? (imask_ff & ~wmask[1:0]) | wd[1:0] : imask_ff;
      istat_ff <= nxt_istat;
      irq_ff <= |(nxt_istat & imask_ff);
      popup_ff <= nxt_popup;
    end
  end

  // buffer pointers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_q_ff <= '0;
      trip_q_ff <= '0;
      pend_ff <= '0;
      cnt_ff <= '0;
      tail_ff <= '0;
      rd_off_ff <= '0;
      pan_off_ff <= '0;
      shadow_ff <= '0;
      shadow_v_ff <= 1'b0;
    end else begin
      start_q_ff <= stage_start;
      trip_q_ff <= stage_trip;
      pend_ff <= (pend_ff & ~(ev_go ? NEV'(1) << sel : '0)) | (trans & ~mask_ff);
      cnt_ff <= clr_go ? '0 : nxt_cnt;
      tail_ff <= clr_go ? '0 : drop ? tail_inc : tail_ff;
      rd_off_ff <= clr_go ? '0 : nxt_rd_off;
      pan_off_ff <= clr_go ? '0 : nxt_pan_off;
      shadow_ff <= pop_ok ? pop_e : shadow_ff;
      shadow_v_ff <= clr_go ? 1'b0 : (pop_ok || shadow_v_ff);
    end
  end

  assign awready = awready_ff;
  assign wready = awready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rresp = rresp_ff;
  assign rdata = rdata_ff;
  assign popup = popup_ff;
  assign irq = irq_ff;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_wr_take;
    awvalid && awready_ff && wvalid;
  endsequence
  sequence s_pop_plain;
    pop_ok && !drop && !clr_go;
  endsequence
  sequence s_pop_empty;
    pop_go && !pop_ok && !drop && !clr_go;
  endsequence

  // pointers, overflow marking and indications
  a_cnt_bound: assert property (cnt_ff <= cap_ff && rd_off_ff <= cnt_ff) else $error("count past capacity");
  a_cap_range: assert property (cap_ff >= CAP_MIN && cap_ff <= CAP_MAX) else $error("capacity out of range");
  a_pop_adv: assert property (s_pop_plain |=> rd_off_ff == $past(rd_off_ff) + 1'b1) else $error("pop did not advance");
  a_reread_hold: assert property (ar_take && araddr == `PEL_REREAD && !drop && !clr_go |=>
    rd_off_ff == $past(rd_off_ff) ##0 rdata_ff == code(shadow_ff, shadow_v_ff)) else $error("reread moved pointer");
  a_mask_block: assert property (ev_go |-> !mask_ff[sel]) else $error("masked event logged");
  a_full_drop: assert property (drop |=> cnt_ff == $past(cnt_ff) && tail_ff != $past(tail_ff)) else $error("oldest not dropped");
  a_ovf_mark: assert property (drop |=> mem[$past(wr_idx)].ovf) else $error("marker missing");
  a_ovf_clean: assert property (ev_go && !full |=> !mem[$past(wr_idx)].ovf) else $error("stray marker");
  a_clear_empty: assert property (clr_go |=> cnt_ff == '0 && rd_off_ff == '0 && pan_off_ff == '0) else $error("clear failed");
  a_popup_gate: assert property (!cfg_ff[`PEL_CTRL_POPUP] |=> !popup_ff) else $error("popup while disabled");
  a_popup_set: assert property (ev_go && cfg_ff[`PEL_CTRL_POPUP] |=> popup_ff)
    else $error("popup not raised");
  a_pan_range: assert property (cnt_ff == '0 ? pan_off_ff == '0 : pan_off_ff < cnt_ff)
    else $error("panel cursor out of range");
  a_pop_empty: assert property (s_pop_empty |=> rdata_ff == 32'h0 && rd_off_ff == $past(rd_off_ff))
    else $error("empty pop not zero");
  a_irq_level: assert property (irq_ff == |(istat_ff & $past(imask_ff))) else $error("irq level wrong");
  a_wr_resp: assert property (s_wr_take |=> bvalid_ff throughout (!awready_ff)[*1]) else $error("no write response"); 
endmodule // pel_event_log
`default_nettype wire

// File: verif/pel_poller_model.sv
// remote poller model: axi4-lite master that reads and writes the event log
`timescale 1ns/1ps
`default_nettype none
`include "pel_regs.svh"
module pel_poller_model (
  // clock
  input wire logic aclk,
  // write channels
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  // read channels
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // address and data may be taken in either order
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // each channel is released at the edge that takes it
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (awready === 1'b1 && !aw_done) begin
        awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (wready === 1'b1 && !w_done) begin
        wvalid <= 1'b0;
        w_done = 1'b1;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // one event per access, the device advances its pointer
  task automatic pop(output logic [31:0] d);
    logic [1:0] r;
    rd(`PEL_POP, d, r);
  endtask
endmodule // pel_poller_model
`default_nettype wire

// File: verif/protection_event_log_buffer_test.sv
// self-checking bench of the protection event log
`timescale 1ns/1ps
`default_nettype none
`include "pel_regs.svh"
module protection_event_log_buffer_test import pel_pkg::*; ;
  localparam logic [7:0] CHB = 8'h30;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, popup, irq;
  logic [7:0] awaddr, araddr, stage_start, stage_trip;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [15:0] fault_pu, fault_pri;
  pel_stamp_t stamp;
  int miscompares, checked;
  pel_event_log #(.NSTG(8), .MAX_DEPTH(2000), .CH_BASE(CHB)) dut (.aclk, .aresetn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .stage_start, .stage_trip, .stamp, .fault_pu, .fault_pri, .popup, .irq);
  pel_poller_model poller (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  function automatic logic [31:0] code(input logic ovf, input int s, input pel_evt_t t);
    return {1'b1, ovf, 14'h0, CHB + 8'(s), 6'h0, t};
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] e, input string n);
    poller.rd(a, d, r);
    chk(n, e, d);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    poller.wr(a, v, r);
    chk("bresp", `PEL_RESP_OKAY, r);
  endtask
  // one stage level change, then time for store and irq
  task automatic stg(input logic tr, input int s, input logic v);
    @(posedge aclk);
    if (tr) stage_trip[s] <= v;
    else stage_start[s] <= v;
    repeat (4) @(posedge aclk);
  endtask
  task summarize;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    summarize;
  end
  initial begin
    logic tr[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    logic lv[4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    pel_evt_t ty[4] = '{PEL_START_ON, PEL_TRIP_ON, PEL_TRIP_OFF, PEL_START_OFF};
    aresetn = 1'b0;
    stage_start = 8'h00;
    stage_trip = 8'h00;
    stamp = {32'h07e8_0315, 32'h01d1_9905};
    fault_pu = 16'h1111;
    fault_pri = 16'h2222;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rreg(`PEL_CTRL, 32'h4, "ctrl");
    rreg(`PEL_CAP, 32'd200, "cap");
    rreg(`PEL_COUNT, 32'h0, "count");
    poller.rd(8'h3c, d, r);
    chk("unmapped resp", `PEL_RESP_SLVERR, r);
    wreg(`PEL_IRQ_MASK, 32'h3);
    stg(1'b0, 1, 1'b1);
    chk("popup", 32'h1, popup);
    chk("irq", 32'h1, irq);
    rreg(`PEL_COUNT, 32'h0001_0001, "count");
    rreg(`PEL_IRQ_STAT, 32'h1, "istat");
    rreg(`PEL_POP, code(1'b0, 1, PEL_START_ON), "pop");
    rreg(`PEL_DATE, 32'h07e8_0315, "date");
    rreg(`PEL_TIME, 32'h01d1_9905, "time");
    rreg(`PEL_FAULT, 32'h1111, "fault pu");
    repeat (2) rreg(`PEL_REREAD, code(1'b0, 1, PEL_START_ON), "reread");
    rreg(`PEL_POP, 32'h0, "pop empty");
    wreg(`PEL_IRQ_STAT, 32'h1);
    repeat (2) @(posedge aclk);
    chk("irq cleared", 32'h0, irq);
    wreg(`PEL_PANEL_CTRL, 32'h4);
    chk("popup ack", 32'h0, popup);
    wreg(`PEL_CTRL, 32'h2);
    for (int k = 0; k < 4; k++) begin
      stg(tr[k], 2, lv[k]);
      rreg(`PEL_POP, code(1'b0, 2, ty[k]), "stage code");
      rreg(`PEL_FAULT, 32'h2222, "fault pri");
    end
    chk("popup off", 32'h0, popup);
    wreg(`PEL_MASK, 32'h0000_1000);
    stg(1'b0, 3, 1'b1);
    rreg(`PEL_COUNT, 32'h0000_0005, "masked count");
    stg(1'b0, 3, 1'b0);
    rreg(`PEL_COUNT, 32'h0001_0006, "unmasked count");
    wreg(`PEL_PANEL_CTRL, 32'h1);
    rreg(`PEL_PANEL_CTRL, 32'h1, "cursor fwd");
    rreg(`PEL_PANEL_CODE, code(1'b0, 2, PEL_START_ON), "panel code");
    rreg(`PEL_PANEL_TIME, 32'h01d1_9905, "panel time");
    wreg(`PEL_PANEL_CTRL, 32'h2);
    rreg(`PEL_PANEL_CTRL, 32'h0, "cursor back");
    rreg(`PEL_PANEL_CODE, code(1'b0, 1, PEL_START_ON), "panel code");
    wreg(`PEL_PANEL_CTRL, 32'h1);
    wreg(`PEL_CTRL, 32'h3);
    wreg(`PEL_PANEL_CTRL, 32'h1);
    rreg(`PEL_PANEL_CTRL, 32'h0, "newest-first fwd");
    rreg(`PEL_POP, code(1'b0, 3, PEL_START_OFF), "pop after panel");
    wreg(`PEL_CTRL, 32'h8);
    rreg(`PEL_COUNT, 32'h0, "count cleared");
    poller.rd(`PEL_REREAD, d, r);
    chk("reread valid", 32'h0, d[31]);
    rreg(`PEL_CTRL, 32'h0, "ctrl clear bit");
    wreg(`PEL_CAP, 32'd10);
    rreg(`PEL_CAP, 32'd50, "cap low");
    wreg(`PEL_CAP, 32'd5000);
    rreg(`PEL_CAP, 32'd2000, "cap high");
    wreg(`PEL_CAP, 32'd50);
    for (int i = 0; i < 51; i++) stg(1'b0, 0, ~i[0]);
    rreg(`PEL_COUNT, 32'h0032_0032, "full count");
    rreg(`PEL_IRQ_STAT, 32'h3, "istat ovf");
    for (int k = 0; k < 50; k++) begin
      poller.pop(d);
      if (k == 0) chk("oldest kept", code(1'b0, 0, PEL_START_OFF), d);
    end
    chk("newest marked", code(1'b1, 0, PEL_START_ON), d);
    summarize;
  end
endmodule // protection_event_log_buffer_test
`default_nettype wire
